//--- logic/plm_consts.svh
// Constants for the link power manager: register offsets, field positions,
// reset values and timing counts.
// Assumes a 125 MHz core clock and a byte-addressed AXI4-Lite register window.
`ifndef PLM_CONSTS_SVH
`define PLM_CONSTS_SVH

// Core clock and timing figures.
`define PLM_CLK_PERIOD_NS      8
`define PLM_L0S_IDLE_NS        6000
`define PLM_L0S_IDLE_CYCLES    ((`PLM_L0S_IDLE_NS + `PLM_CLK_PERIOD_NS - 1) / `PLM_CLK_PERIOD_NS)
`define PLM_PME_SAMPLE_NS      100000
`define PLM_PME_SAMPLE_CYCLES  (`PLM_PME_SAMPLE_NS / `PLM_CLK_PERIOD_NS)

// Register window.
`define PLM_ADDR_W             8
`define PLM_OFS_CTRL           8'h00
`define PLM_OFS_PMCSR          8'h04
`define PLM_OFS_LINK_CAP       8'h08
`define PLM_OFS_STATUS         8'h0C

// Control register: command enables and active-state control field.
`define PLM_CTRL_MEM_EN        0
`define PLM_CTRL_IO_EN         1
`define PLM_CTRL_BM_EN         2
`define PLM_CTRL_ASPM_LSB      4
`define PLM_CTRL_WMASK         32'h0000_0037
`define PLM_CTRL_CMD_MASK      32'h0000_0007
`define PLM_CTRL_RESET         32'h0000_0000

// Power management control and status register.
`define PLM_PMCSR_PS_LSB       0
`define PLM_PMCSR_NSR          3
`define PLM_PMCSR_PME_EN       8
`define PLM_PMCSR_PME_STATUS   15
`define PLM_PS_D0              2'h0
`define PLM_PS_D3HOT           2'h3

// Link capabilities: active-state support field, L0s only.
`define PLM_LINK_CAP_VALUE     32'h0000_0400

// Status register fields.
`define PLM_STAT_LINK_LSB      0
`define PLM_STAT_DEV_LSB       4
`define PLM_STAT_PLL_ON        7

// AXI responses.
`define PLM_RESP_OKAY          2'h0
`define PLM_RESP_SLVERR        2'h2

`endif

//--- logic/plm_pkg.sv
// Types shared by the link power manager files.
// Assumes plm_consts.svh is on the include path.
`include "plm_consts.svh"

package plm_pkg;

  // Link power states, including the pseudo state before the first L0.
  typedef enum logic [2:0] {
    LINK_DOWN,
    LINK_L0,
    LINK_L0S,
    LINK_L1,
    LINK_L23_READY,
    LINK_L3
  } plm_link_state_type;

  // Device power states; D1 and D2 do not exist here.
  typedef enum logic [1:0] {
    DEV_D0_UNINIT,
    DEV_D0_ACTIVE,
    DEV_D3_HOT,
    DEV_D3_COLD
  } plm_dev_state_type;

  // One register write as handed from the bus slave to the register file.
  typedef struct packed {
    logic [`PLM_ADDR_W-1:0] addr;
    logic [31:0]            data;
    logic [3:0]             strb;
  } plm_wr_type;

endpackage

//--- logic/plm_tick_counter.sv
// Up-counter with clear, run and a compare against a limit.
// Assumes the caller decides whether it saturates or wraps via clear and run.
module plm_tick_counter (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clear,
  input  wire logic        run,
  input  wire logic [15:0] limit,
  output logic             at_limit
);

  logic [15:0] count;

  // Clear has priority so a restarted interval never carries an old count.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count <= 16'h0000;
    else if (clear)
      count <= 16'h0000;
    else if (run)
      count <= count + 16'h0001;
  end

  assign at_limit = (count == limit);

endmodule

//--- logic/plm_axil_slave.sv
// AXI4-Lite slave front end: accepts address and data in either order,
// hands one write or one read to the register file, returns the response.
// Assumes read data and the decode result are combinational from the address.
`include "plm_consts.svh"
module plm_axil_slave (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`PLM_ADDR_W-1:0] awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [`PLM_ADDR_W-1:0] araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  output plm_pkg::plm_wr_type         wr,
  output logic                        wr_en,
  input  wire logic                   wr_ok,
  output logic [`PLM_ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]            rd_data,
  input  wire logic                   rd_ok
);

  logic                   aw_held;
  logic                   w_held;
  logic [`PLM_ADDR_W-1:0] aw_addr;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   next_aw_held;
  logic                   next_w_held;
  logic                   next_bvalid;
  logic                   next_rvalid;
  wire                    aw_take = awvalid && awready;
  wire                    w_take  = wvalid && wready;
  wire                    ar_take = arvalid && arready;

  // The write fires once both halves are held; readies stay low until the response is taken.
  assign wr_en        = aw_held && w_held && !bvalid;
  assign wr           = '{addr: aw_addr, data: w_data, strb: w_strb};
  assign next_aw_held = (aw_held || aw_take) && !wr_en;
  assign next_w_held  = (w_held || w_take) && !wr_en;
  assign next_bvalid  = wr_en || (bvalid && !bready);
  assign next_rvalid  = ar_take || (rvalid && !rready);
  assign rd_addr      = araddr;

  // Write channel registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `PLM_RESP_OKAY;
      aw_addr <= '0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      awready <= !next_aw_held && !next_bvalid;
      wready  <= !next_w_held && !next_bvalid;
      bvalid  <= next_bvalid;
      if (aw_take)
        aw_addr <= awaddr;
      if (w_take)
      begin
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (wr_en)
        bresp <= wr_ok ? `PLM_RESP_OKAY : `PLM_RESP_SLVERR;
    end
  end

  // Read channel registers; data are captured on the address handshake.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `PLM_RESP_OKAY;
    end
    else
    begin
      arready <= !next_rvalid;
      rvalid  <= next_rvalid;
      if (ar_take)
      begin
        rdata <= rd_ok ? rd_data : 32'h0000_0000;
        rresp <= rd_ok ? `PLM_RESP_OKAY : `PLM_RESP_SLVERR;
      end
    end
  end

endmodule

//--- logic/plm_power_manager.sv
// Link and device power manager: device power states, link power states,
// the L0s idle timer and the power-management-event sampler.
// Assumes the physical layer follows link_state and gates packets with tx_allowed.
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`include "plm_consts.svh"
module plm_power_manager #(
  parameter int unsigned PME_SAMPLE_CYCLES = `PLM_PME_SAMPLE_CYCLES
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`PLM_ADDR_W-1:0] s_axil_awaddr,
  input  wire logic                   s_axil_awvalid,
  output logic                        s_axil_awready,
  input  wire logic [31:0]            s_axil_wdata,
  input  wire logic [3:0]             s_axil_wstrb,
  input  wire logic                   s_axil_wvalid,
  output logic                        s_axil_wready,
  output logic [1:0]                  s_axil_bresp,
  output logic                        s_axil_bvalid,
  input  wire logic                   s_axil_bready,
  input  wire logic [`PLM_ADDR_W-1:0] s_axil_araddr,
  input  wire logic                   s_axil_arvalid,
  output logic                        s_axil_arready,
  output logic [31:0]                 s_axil_rdata,
  output logic [1:0]                  s_axil_rresp,
  output logic                        s_axil_rvalid,
  input  wire logic                   s_axil_rready,
  input  wire logic                   link_up,
  input  wire logic                   tx_pending,
  input  wire logic                   tx_active,
  input  wire logic                   rx_activity,
  input  wire logic                   pcix_activity,
  input  wire logic                   upstream_l1_exit,
  input  wire logic                   turn_off_msg,
  input  wire logic                   main_power_off,
  input  wire logic                   pm_event_input_pin_n,
  output plm_pkg::plm_link_state_type link_state,
  output plm_pkg::plm_dev_state_type  dev_state,
  output logic                        tx_allowed,
  output logic                        rx_accept,
  output logic                        pll_enable,
  output logic                        func_enable,
  output logic                        turn_off_ack,
  output logic                        pm_event_message
);

  plm_pkg::plm_wr_type        wr;
  logic                       wr_en;
  logic [`PLM_ADDR_W-1:0]     rd_addr;
  logic [31:0]                rd_data;
  logic                       rd_ok;
  logic                       wr_ok;
  logic [31:0]                ctrl;
  logic                       no_soft_reset;
  logic                       pme_en;
  logic                       pme_status;
  logic                       pme_pending;
  logic                       l1_request;
  logic                       idle_at_limit;
  logic                       sample_tick;
  logic [31:0]                wmask;
  logic [31:0]                next_ctrl;
  plm_pkg::plm_dev_state_type next_dev;
  plm_pkg::plm_link_state_type next_link;
  logic                       next_nsr;
  logic                       next_l1_request;
  logic                       next_ack;

  // Register bus front end; configuration accesses are served in every device state.
  plm_axil_slave u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axil_awaddr),
    .awvalid (s_axil_awvalid),
    .awready (s_axil_awready),
    .wdata   (s_axil_wdata),
    .wstrb   (s_axil_wstrb),
    .wvalid  (s_axil_wvalid),
    .wready  (s_axil_wready),
    .bresp   (s_axil_bresp),
    .bvalid  (s_axil_bvalid),
    .bready  (s_axil_bready),
    .araddr  (s_axil_araddr),
    .arvalid (s_axil_arvalid),
    .arready (s_axil_arready),
    .rdata   (s_axil_rdata),
    .rresp   (s_axil_rresp),
    .rvalid  (s_axil_rvalid),
    .rready  (s_axil_rready),
    .wr      (wr),
    .wr_en   (wr_en),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // Byte lanes turn the write strobes into a bit mask.
  for (genvar lane = 0; lane < 4; lane++)
  begin : g_lane
    assign wmask[8*lane +: 8] = {8{wr.strb[lane]}};
  end

  // Address decode for writes and reads.
  wire wr_ctrl  = wr_en && (wr.addr == `PLM_OFS_CTRL);
  wire wr_pmcsr = wr_en && (wr.addr == `PLM_OFS_PMCSR);
  assign wr_ok  = (wr.addr == `PLM_OFS_CTRL) || (wr.addr == `PLM_OFS_PMCSR) ||
                  (wr.addr == `PLM_OFS_LINK_CAP) || (wr.addr == `PLM_OFS_STATUS);
  assign rd_ok  = (rd_addr == `PLM_OFS_CTRL) || (rd_addr == `PLM_OFS_PMCSR) ||
                  (rd_addr == `PLM_OFS_LINK_CAP) || (rd_addr == `PLM_OFS_STATUS);

  // Power state field as software sees it; both D0 sub-states read as D0.
  wire       in_d3hot    = (dev_state == plm_pkg::DEV_D3_HOT);
  wire       in_d0       = (dev_state == plm_pkg::DEV_D0_UNINIT) || (dev_state == plm_pkg::DEV_D0_ACTIVE);
  wire [1:0] ps_field    = in_d0 ? `PLM_PS_D0 : `PLM_PS_D3HOT;
  wire [1:0] ps_written  = wr.data[`PLM_PMCSR_PS_LSB +: 2];
  wire       ps_lane     = wr_pmcsr && wr.strb[0];
  // Writes coding D1 or D2 match neither compare and are ignored.
  wire       write_d0    = ps_lane && (ps_written == `PLM_PS_D0);
  wire       write_d3hot = ps_lane && (ps_written == `PLM_PS_D3HOT);
  wire       back_to_d0  = write_d0 && in_d3hot;
  wire       l0s_enabled = ctrl[`PLM_CTRL_ASPM_LSB];

  wire [31:0] pmcsr_value = {16'h0000, pme_status, 6'h00, pme_en, 4'h0, no_soft_reset, 1'b0, ps_field};
  wire [31:0] status_value = {24'h00_0000, pll_enable, 1'b0, dev_state, 1'b0, link_state};

  // Read multiplexer; the link capabilities word advertises L0s support only.
  assign rd_data = (rd_addr == `PLM_OFS_CTRL)     ? ctrl :
                   (rd_addr == `PLM_OFS_PMCSR)    ? pmcsr_value :
                   (rd_addr == `PLM_OFS_LINK_CAP) ? `PLM_LINK_CAP_VALUE :
                   (rd_addr == `PLM_OFS_STATUS)   ? status_value :
                   32'h0000_0000;

  // Control register update; going back to D0 drops the enables so the function is uninitialized.
  always_comb
  begin
    next_ctrl = ctrl;
    if (wr_ctrl)
      next_ctrl = (ctrl & ~(wmask & `PLM_CTRL_WMASK)) | (wr.data & wmask & `PLM_CTRL_WMASK);
    if (back_to_d0)
      next_ctrl = next_ctrl & ~`PLM_CTRL_CMD_MASK;
  end

  // Device power state machine.
  always_comb
  begin
    next_dev        = dev_state;
    next_nsr        = no_soft_reset;
    next_l1_request = l1_request;
    unique case (dev_state)
      plm_pkg::DEV_D0_UNINIT,
      plm_pkg::DEV_D0_ACTIVE:
      begin
        if (write_d3hot)
        begin
          next_dev        = plm_pkg::DEV_D3_HOT;
          next_l1_request = 1'b1;
        end
        else if (dev_state == plm_pkg::DEV_D0_UNINIT && (next_ctrl & `PLM_CTRL_CMD_MASK) != 32'h0000_0000)
          next_dev = plm_pkg::DEV_D0_ACTIVE;
      end
      plm_pkg::DEV_D3_HOT:
      begin
        if (back_to_d0)
        begin
          next_dev        = plm_pkg::DEV_D0_UNINIT;
          next_nsr        = 1'b1;
          next_l1_request = 1'b0;
        end
        // A repeated D3hot write asks for L1 again after an earlier exit.
        else if (write_d3hot)
          next_l1_request = 1'b1;
      end
      plm_pkg::DEV_D3_COLD:
        next_dev = plm_pkg::DEV_D3_COLD;
    endcase
    if (main_power_off)
      next_dev = plm_pkg::DEV_D3_COLD;
    if (next_link == plm_pkg::LINK_L1)
      next_l1_request = 1'b0;
  end

  // Idle timer: counts cycles with nothing to send while L0s is allowed, and holds at the limit.
  wire tx_idle   = !tx_active && !tx_pending;
  wire idle_run  = (link_state == plm_pkg::LINK_L0) && l0s_enabled && tx_idle;

  plm_tick_counter u_idle_timer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clear    (!idle_run),
    .run      (!idle_at_limit),
    .limit    (16'(`PLM_L0S_IDLE_CYCLES)),
    .at_limit (idle_at_limit)
  );

  // Event pin sampler: one tick per sample period, free running.
  plm_tick_counter u_pme_sampler (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clear    (sample_tick),
    .run      (1'b1),
    .limit    (16'(PME_SAMPLE_CYCLES - 1)),
    .at_limit (sample_tick)
  );

  // An event is taken only at a sample tick and never in D3cold, which has no auxiliary power.
  wire pme_seen   = sample_tick && !pm_event_input_pin_n && pme_en && !pme_pending &&
                    (dev_state != plm_pkg::DEV_D3_COLD);
  wire pme_send   = pme_pending && (link_state == plm_pkg::LINK_L0) && !tx_active;
  wire pme_clear  = wr_pmcsr && wr.strb[1] && wr.data[`PLM_PMCSR_PME_STATUS];
  wire wake       = tx_pending || rx_activity || pcix_activity || pme_pending;
  wire link_alive = (link_state == plm_pkg::LINK_L0) || (link_state == plm_pkg::LINK_L0S) ||
                    (link_state == plm_pkg::LINK_L1);

  // Link power state machine; power removal wins, then link loss, then the turn-off message.
  always_comb
  begin
    next_link = link_state;
    next_ack  = 1'b0;
    unique case (link_state)
      plm_pkg::LINK_DOWN:
        if (link_up)
          next_link = plm_pkg::LINK_L0;
      plm_pkg::LINK_L0:
      begin
        if (turn_off_msg)
          next_link = plm_pkg::LINK_L23_READY;
        else if (l1_request && !tx_active && !pme_pending)
          next_link = plm_pkg::LINK_L1;
        else if (idle_at_limit && idle_run)
          next_link = plm_pkg::LINK_L0S;
      end
      plm_pkg::LINK_L0S:
      begin
        if (turn_off_msg)
          next_link = plm_pkg::LINK_L23_READY;
        else if (wake)
          next_link = plm_pkg::LINK_L0;
      end
      plm_pkg::LINK_L1:
      begin
        if (turn_off_msg)
          next_link = plm_pkg::LINK_L23_READY;
        else if (upstream_l1_exit || wake)
          next_link = plm_pkg::LINK_L0;
      end
      plm_pkg::LINK_L23_READY:
        next_link = plm_pkg::LINK_L23_READY;
      plm_pkg::LINK_L3:
        next_link = plm_pkg::LINK_L3;
      default:
        next_link = plm_pkg::LINK_DOWN;
    endcase
    if (link_alive && turn_off_msg)
      next_ack = 1'b1;
    if (link_alive && !link_up)
    begin
      next_link = plm_pkg::LINK_DOWN;
      next_ack  = 1'b0;
    end
    if (main_power_off && link_state != plm_pkg::LINK_L3)
    begin
      next_link = plm_pkg::LINK_L3;
      next_ack  = 1'b0;
    end
  end

  // Register file and power state registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl          <= `PLM_CTRL_RESET;
      dev_state     <= plm_pkg::DEV_D0_UNINIT;
      no_soft_reset <= 1'b0;
      l1_request    <= 1'b0;
      pme_en        <= 1'b0;
    end
    else
    begin
      ctrl          <= next_ctrl;
      dev_state     <= next_dev;
      no_soft_reset <= next_nsr;
      l1_request    <= next_l1_request;
      if (wr_pmcsr && wr.strb[1])
        pme_en <= wr.data[`PLM_PMCSR_PME_EN];
    end
  end

  // Event status: a new event in the clearing cycle keeps the bit set.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pme_status  <= 1'b0;
      pme_pending <= 1'b0;
    end
    else
    begin
      pme_status  <= pme_seen || (pme_status && !pme_clear);
      pme_pending <= pme_seen || (pme_pending && !pme_send);
    end
  end

  // Link outputs are registered from the next state so they change with it.
  // Packets flow only in L0; the receiver stays open in L0s because only our transmitter sleeps.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      link_state       <= plm_pkg::LINK_DOWN;
      tx_allowed       <= 1'b0;
      rx_accept        <= 1'b0;
      pll_enable       <= 1'b1;
      func_enable      <= 1'b0;
      turn_off_ack     <= 1'b0;
      pm_event_message <= 1'b0;
    end
    else
    begin
      link_state       <= next_link;
      tx_allowed       <= (next_link == plm_pkg::LINK_L0);
      rx_accept        <= (next_link == plm_pkg::LINK_L0) || (next_link == plm_pkg::LINK_L0S);
      pll_enable       <= (next_link != plm_pkg::LINK_L3);
      func_enable      <= (next_dev == plm_pkg::DEV_D0_ACTIVE);
      turn_off_ack     <= next_ack;
      pm_event_message <= pme_send && (next_link == plm_pkg::LINK_L0);
    end
  end

endmodule

//--- tb/plm_upstream_model.sv
// Upstream port model: link training, turn-off broadcast and L1 exit requests.
// Assumes the bench calls its tasks from a process synchronous to aclk.
module plm_upstream_model (
  input  wire logic aclk,
  output logic      link_up,
  output logic      rx_activity,
  output logic      upstream_l1_exit,
  output logic      turn_off_msg
);
  timeunit 1ns;
  timeprecision 1ps;
  // All idle at start, so the device first sees the link down.
  initial {link_up, rx_activity, upstream_l1_exit, turn_off_msg} = 4'h0;
  // Training completes only when the bench says so.
  task automatic train();
    @(posedge aclk) link_up <= 1'h1;
  endtask
  // Requests last one cycle and change right after an edge.
  task automatic exit_l1();
    @(posedge aclk) upstream_l1_exit <= 1'h1;
    @(posedge aclk) upstream_l1_exit <= 1'h0;
  endtask
  task automatic turn_off();
    @(posedge aclk) turn_off_msg <= 1'h1;
    @(posedge aclk) turn_off_msg <= 1'h0;
  endtask
endmodule

//--- tb/plm_power_manager_assertions.sv
// Checker for the link and device state outputs of the power manager.
// Assumes it is bound into plm_power_manager and sees its ports only.
module plm_power_manager_assertions #(
  parameter int unsigned PME_SAMPLE_CYCLES = 12500
) (
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic                        link_up,
  input wire logic                        tx_pending,
  input wire logic                        turn_off_msg,
  input wire logic                        main_power_off,
  input wire plm_pkg::plm_link_state_type link_state,
  input wire plm_pkg::plm_dev_state_type  dev_state,
  input wire logic                        tx_allowed,
  input wire logic                        pll_enable,
  input wire logic                        turn_off_ack,
  input wire logic                        pm_event_message
);
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_tx_gate: assert property (tx_allowed |-> link_state == plm_pkg::LINK_L0)
    else $error("Transmit allowed outside L0");
  a_pll_only_l3: assert property (pll_enable == (link_state != plm_pkg::LINK_L3))
    else $error("PLL enable wrong for link state");
  a_l1_by_d3: assert property (link_state == plm_pkg::LINK_L1 && $past(link_state) != plm_pkg::LINK_L1
    |-> dev_state == plm_pkg::DEV_D3_HOT)
    else $error("L1 entered without D3hot");
  a_no_cold_event: assert property (dev_state == plm_pkg::DEV_D3_COLD |-> !pm_event_message)
    else $error("Event message in D3cold");
  a_l0s_idle: assert property (link_state == plm_pkg::LINK_L0S && $past(link_state) == plm_pkg::LINK_L0
    |-> !$past(tx_pending))
    else $error("L0s entered with traffic pending");
  a_l0s_exit: assert property (link_state == plm_pkg::LINK_L0S && tx_pending && link_up && !turn_off_msg
    && !main_power_off |=> link_state == plm_pkg::LINK_L0 && tx_allowed)
    else $error("No L0s exit on pending traffic");
  a_turn_off_ack: assert property (turn_off_msg && link_up && !main_power_off
    && link_state inside {[plm_pkg::LINK_L0:plm_pkg::LINK_L1]}
    |=> turn_off_ack && link_state == plm_pkg::LINK_L23_READY)
    else $error("Turn-off not acknowledged");
  a_power_off: assert property (main_power_off |=> link_state == plm_pkg::LINK_L3
    && dev_state == plm_pkg::DEV_D3_COLD)
    else $error("Power removal did not reach L3");
  a_event_in_l0: assert property (pm_event_message |-> $past(link_state) == plm_pkg::LINK_L0)
    else $error("Event message sent outside L0");
endmodule
bind plm_power_manager plm_power_manager_assertions #(.PME_SAMPLE_CYCLES(PME_SAMPLE_CYCLES)) u_chk (.*);

//--- tb/plm_power_manager_tb.sv
// Testbench for the link power manager: register accesses and link events.
// Assumes plm_consts.svh on the include path and the upstream model beside it.
`include "plm_consts.svh"
module plm_power_manager_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0, aresetn = 1'h0, tx_pending = 1'h0, main_power_off = 1'h0, pm_event_input_pin_n = 1'h1;
  logic tx_active = 1'h0, pcix_activity = 1'h0;
  logic s_axil_awvalid = 1'h0, s_axil_wvalid = 1'h0, s_axil_bready = 1'h0;
  logic s_axil_arvalid = 1'h0, s_axil_rready = 1'h0;
  logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
  logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata;
  logic [3:0] s_axil_wstrb = 4'hF;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic link_up, rx_activity, upstream_l1_exit, turn_off_msg, tx_allowed, rx_accept;
  logic pll_enable, func_enable, turn_off_ack, pm_event_message;
  plm_pkg::plm_link_state_type link_state;
  plm_pkg::plm_dev_state_type dev_state;
  int error_cnt = 0, tests_run = 0, pme_cnt = 0;
  // Short sample period keeps the event scenario brief.
  plm_power_manager #(.PME_SAMPLE_CYCLES(20)) i_dut (.*);
  plm_upstream_model i_up (.*);
  initial forever #4 aclk = ~aclk;
  // Event pulses last one cycle, so they are counted at every edge.
  always @(posedge aclk) if (pm_event_message === 1'h1) pme_cnt++;
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Address and data go out together; each is dropped once its ready is seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axil_awready) s_axil_awvalid <= 1'h0;
      if (s_axil_wready) s_axil_wvalid <= 1'h0;
    end while (!s_axil_bvalid);
    s_axil_bready <= 1'h0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axil_araddr <= a;
    {s_axil_arvalid, s_axil_rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (s_axil_arready) s_axil_arvalid <= 1'h0;
    end while (!s_axil_rvalid);
    s_axil_rready <= 1'h0;
    chk({s_axil_rresp, s_axil_rdata}, {r, d});
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // A hang counts as a failure; the tests need about 1700 cycles.
  initial
  begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    end_sim();
  end
  // Main sequence: each read compares status or registers with the expected state.
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rc(8'h0C, 32'h80, 2'h0);
    rc(8'h08, 32'h400, 2'h0);
    rc(8'h10, 32'h0, 2'h2);
    i_up.train();
    repeat (800) @(posedge aclk);
    rc(8'h0C, 32'h81, 2'h0);
    wr(8'h00, 32'h11);
    chk({33'h0, func_enable}, 34'h1);
    // Idle starts when the control write lands; L0s must not come before 751 idle edges.
    repeat (748) @(posedge aclk);
    rc(8'h0C, 32'h91, 2'h0);
    @(posedge aclk);
    rc(8'h0C, 32'h92, 2'h0);
    chk({32'h0, tx_allowed, rx_accept}, 34'h1);
    @(posedge aclk) tx_pending <= 1'h1;
    @(posedge aclk) tx_pending <= 1'h0;
    rc(8'h0C, 32'h91, 2'h0);
    wr(8'h04, 32'h3);
    rc(8'h0C, 32'hA3, 2'h0);
    chk({32'h0, tx_allowed, rx_accept}, 34'h0);
    @(posedge aclk) pcix_activity <= 1'h1;
    @(posedge aclk) pcix_activity <= 1'h0;
    rc(8'h0C, 32'hA1, 2'h0);
    // A packet on the wire holds off the second L1 entry until it ends.
    tx_active <= 1'h1;
    wr(8'h04, 32'h3);
    rc(8'h0C, 32'hA1, 2'h0);
    tx_active <= 1'h0;
    rc(8'h0C, 32'hA3, 2'h0);
    i_up.exit_l1();
    rc(8'h0C, 32'hA1, 2'h0);
    wr(8'h04, 32'h0);
    wr(8'h04, 32'h1);
    rc(8'h04, 32'h8, 2'h0);
    wr(8'h04, 32'h100);
    @(posedge aclk) pm_event_input_pin_n <= 1'h0;
    repeat (60) @(posedge aclk);
    pm_event_input_pin_n <= 1'h1;
    rc(8'h04, 32'h8108, 2'h0);
    chk({33'h0, pme_cnt != 0}, 34'h1);
    i_up.turn_off();
    rc(8'h0C, 32'h84, 2'h0);
    @(posedge aclk) main_power_off <= 1'h1;
    rc(8'h0C, 32'h35, 2'h0);
    // Cold reset brings power back; software must initialize the function again.
    aresetn <= 1'h0;
    main_power_off <= 1'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rc(8'h0C, 32'h81, 2'h0);
    rc(8'h04, 32'h0, 2'h0);
    wr(8'h00, 32'h4);
    rc(8'h0C, 32'h91, 2'h0);
    end_sim();
  end
endmodule
